/* File: logic/cec_classifier.sv */
// Summary of operation
// - A non-numeric where a number is expected queues -120 and sets event status bit 5.
// - An exponent out of range queues -123 and sets event status bit 5.
// - A protected command while unlock is inactive queues -203 and sets bit 4; the host unlocks first.
// - A state conflict queues -221, sets bit 4, and names output off, external reference, mode or list running.
// - An over-rating or out-of-range value queues -222 and sets bit 4.
// - A known failing parameter tags the -222 entry as voltage, current or dwell.
// - A list that fills during loading queues -223 and sets bit 4.
// - A dwell list length other than 1 and unequal to the voltage or current list length queues -226 with bit 4.
// - The list mismatch also exists as a too-small form with code -226 and bit 4.
// - An error arriving on a full queue records -350 so the loss is visible.
// - An input longer than 253 characters records -363.
`timescale 1ns/1ps
`default_nettype none
module cec_classifier #(
  parameter int DEPTH = 16,
  parameter int QW = 3
) (
  // Clock and reset.
  input wire logic CLOCK,
  input wire logic RESETN,
  // Fault report from the parser.
  input wire logic FAULT_VALID,
  input wire cec_pkg::cec_fault_t FAULT_KIND,
  input wire logic [2:0] FAULT_QUAL,
  input wire logic PASSWORD_UNLOCK_ACTIVE,
  // Characters of the current input message.
  input wire logic CHAR_VALID,
  input wire logic MSG_END,
  // Queue read by the host.
  input wire logic QUEUE_READ,
  output logic [15:0] ERR_CODE,
  output logic [2:0] ERR_QUAL,
  output logic QUEUE_EMPTY,
  // Event status register.
  input wire logic ESR_CLEAR,
  output logic [cec_pkg::ESR_W-1:0] ESR,
  // Gate for applying a command's settings.
  output logic CMD_ACCEPT
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = 9;
  localparam logic [CW-1:0] MAX_CHARS = CW'(cec_pkg::MAX_MSG_CHARS);

  logic [15:0] mem_code [DEPTH];
  logic [QW-1:0] mem_qual [DEPTH];
  logic [AW-1:0] rd_q, rd_d, wr_q, wr_d;
  logic [AW:0] cnt_q, cnt_d;
  logic [cec_pkg::ESR_W-1:0] esr_q, esr_d;
  logic [CW-1:0] chars_q, chars_d;
  logic ovr_q, ovr_d;
  logic [15:0] code_q, code_d;
  logic [2:0] qual_q, qual_d;
  logic push;
  logic [15:0] push_code;
  logic [QW-1:0] push_qual;
  logic push_cmd, push_exe, push_dev;
  logic pop;

  // Classifies a fault kind into its error code.
  function automatic logic [15:0] code_of(cec_pkg::cec_fault_t k);
    unique case (k)
      cec_pkg::CEC_F_NONE: code_of = cec_pkg::ERR_NONE;
      cec_pkg::CEC_F_NUMERIC: code_of = cec_pkg::ERR_NUMERIC;
      cec_pkg::CEC_F_EXPONENT: code_of = cec_pkg::ERR_EXPONENT;
      cec_pkg::CEC_F_PROTECTED: code_of = cec_pkg::ERR_PROTECTED;
      cec_pkg::CEC_F_CONFLICT: code_of = cec_pkg::ERR_CONFLICT;
      cec_pkg::CEC_F_RANGE: code_of = cec_pkg::ERR_RANGE;
      cec_pkg::CEC_F_TOO_MUCH: code_of = cec_pkg::ERR_TOO_MUCH;
      cec_pkg::CEC_F_ILLEGAL: code_of = cec_pkg::ERR_ILLEGAL;
      cec_pkg::CEC_F_LIST_LEN: code_of = cec_pkg::ERR_LIST_LEN;
      cec_pkg::CEC_F_OVERRUN: code_of = cec_pkg::ERR_OVERRUN;
      default: code_of = cec_pkg::ERR_NONE;
    endcase
  endfunction

  // Protected reports only count while unlock is inactive; the parser may report them anyway.
  logic fault_live;
  assign fault_live = FAULT_VALID && FAULT_KIND != cec_pkg::CEC_F_NONE &&
    !(FAULT_KIND == cec_pkg::CEC_F_PROTECTED && PASSWORD_UNLOCK_ACTIVE);

  // Message length counter; overrun raised once when the limit is passed.
  logic overrun_ev;
  always_comb begin
    chars_d = chars_q;
    ovr_d = ovr_q;
    overrun_ev = 1'b0;
    if (CHAR_VALID && !ovr_q) begin
      if (chars_q == MAX_CHARS) begin
        ovr_d = 1'b1;
        overrun_ev = 1'b1;
      end else begin
        chars_d = chars_q + CW'(1);
      end
    end
    if (MSG_END) begin
      chars_d = '0;
      ovr_d = 1'b0;
    end
  end

  // Overrun has priority over a same-cycle parser fault, which is then dropped.
  always_comb begin
    push = 1'b0;
    push_code = cec_pkg::ERR_NONE;
    push_qual = QW'(cec_pkg::Q_NONE);
    push_cmd = 1'b0;
    push_exe = 1'b0;
    push_dev = 1'b0;
    if (overrun_ev) begin
      push = 1'b1;
      push_code = cec_pkg::ERR_OVERRUN;
      push_dev = 1'b1;
    end else if (fault_live) begin
      push = 1'b1;
      push_code = code_of(FAULT_KIND);
      push_cmd = FAULT_KIND inside {cec_pkg::CEC_F_NUMERIC, cec_pkg::CEC_F_EXPONENT};
      push_exe = !push_cmd && FAULT_KIND != cec_pkg::CEC_F_OVERRUN;
      push_dev = FAULT_KIND == cec_pkg::CEC_F_OVERRUN;
      if (FAULT_KIND inside {cec_pkg::CEC_F_CONFLICT, cec_pkg::CEC_F_RANGE, cec_pkg::CEC_F_LIST_LEN}) begin
        push_qual = QW'(FAULT_QUAL);
      end
    end
  end

  assign pop = QUEUE_READ;

  // Queue pointers and the read-out register.
  always_comb begin
    rd_d = rd_q;
    wr_d = wr_q;
    cnt_d = cnt_q;
    code_d = code_q;
    qual_d = qual_q;
    if (pop) begin
      if (cnt_q != '0) begin
        code_d = mem_code[rd_q];
        qual_d = 3'(mem_qual[rd_q]);
        rd_d = (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + AW'(1);
      end else begin
        code_d = cec_pkg::ERR_NONE;
        qual_d = cec_pkg::Q_NONE;
      end
    end
    if (push && (cnt_q - (pop && cnt_q != '0 ? (AW+1)'(1) : '0)) < (AW+1)'(DEPTH)) begin
      wr_d = (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + AW'(1);
    end
    cnt_d = cnt_q + ((push && (cnt_q - (pop && cnt_q != '0 ? (AW+1)'(1) : '0)) < (AW+1)'(DEPTH)) ? (AW+1)'(1) : '0)
      - ((pop && cnt_q != '0) ? (AW+1)'(1) : '0);
  end

  // Free space after this cycle's pop decides between storing and overflow marking.
  logic room, store;
  logic [AW-1:0] last_idx;
  assign room = (cnt_q - ((pop && cnt_q != '0) ? (AW+1)'(1) : '0)) < (AW+1)'(DEPTH);
  assign store = push && room;
  assign last_idx = (wr_q == '0) ? AW'(DEPTH - 1) : wr_q - AW'(1);

  always_ff @(posedge CLOCK) begin
    if (store) begin
      mem_code[wr_q] <= push_code;
      mem_qual[wr_q] <= push_qual;
    end else if (push) begin
      mem_code[last_idx] <= cec_pkg::ERR_OVERFLOW;
      mem_qual[last_idx] <= QW'(cec_pkg::Q_NONE);
    end
  end

  // Event status bits; a new event wins over a same-cycle clear.
  always_comb begin
    esr_d = ESR_CLEAR ? cec_pkg::ESR_RESET : esr_q;
    if (push_cmd) esr_d[cec_pkg::ESR_CMD_BIT] = 1'b1;
    if (push_exe) esr_d[cec_pkg::ESR_EXE_BIT] = 1'b1;
    if (push_dev || (push && !room)) esr_d[cec_pkg::ESR_DEV_BIT] = 1'b1;
  end

  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      rd_q <= '0;
      wr_q <= '0;
      cnt_q <= '0;
      esr_q <= cec_pkg::ESR_RESET;
      chars_q <= '0;
      ovr_q <= 1'b0;
      code_q <= cec_pkg::ERR_NONE;
      qual_q <= cec_pkg::Q_NONE;
    end else begin
      rd_q <= rd_d;
      wr_q <= wr_d;
      cnt_q <= cnt_d;
      esr_q <= esr_d;
      chars_q <= chars_d;
      ovr_q <= ovr_d;
      code_q <= code_d;
      qual_q <= qual_d;
    end
  end

  assign ERR_CODE = code_q;
  assign ERR_QUAL = qual_q;
  assign QUEUE_EMPTY = cnt_q == '0;
  assign ESR = esr_q;
  // Settings may only be applied for a command that raised no fault.
  assign CMD_ACCEPT = !(FAULT_VALID && fault_live);

  chk_cmd_bit_set: assert property (@(posedge CLOCK) disable iff (!RESETN)
    (fault_live && FAULT_KIND == cec_pkg::CEC_F_NUMERIC && !overrun_ev) |=> ESR[cec_pkg::ESR_CMD_BIT])
    else $error("numeric error did not set command bit");
  chk_exp_no_exe: assert property (@(posedge CLOCK) disable iff (!RESETN)
    (fault_live && FAULT_KIND == cec_pkg::CEC_F_EXPONENT && !overrun_ev && !ESR_CLEAR && !esr_q[cec_pkg::ESR_EXE_BIT])
    |=> !ESR[cec_pkg::ESR_EXE_BIT] && ESR[cec_pkg::ESR_CMD_BIT])
    else $error("exponent error set wrong status bit");
  chk_protect_unlocked: assert property (@(posedge CLOCK) disable iff (!RESETN)
    (FAULT_VALID && FAULT_KIND == cec_pkg::CEC_F_PROTECTED && PASSWORD_UNLOCK_ACTIVE) |-> !push || overrun_ev)
    else $error("protected command queued while unlocked");
  chk_exe_bit_set: assert property (@(posedge CLOCK) disable iff (!RESETN)
    (fault_live && FAULT_KIND == cec_pkg::CEC_F_RANGE && !overrun_ev) |=> ESR[cec_pkg::ESR_EXE_BIT])
    else $error("range error did not set execution bit");
  chk_set_beats_clear: assert property (@(posedge CLOCK) disable iff (!RESETN)
    (push_exe && ESR_CLEAR) |=> ESR[cec_pkg::ESR_EXE_BIT])
    else $error("same-cycle clear hid an execution error");
  chk_empty_zero: assert property (@(posedge CLOCK) disable iff (!RESETN)
    (pop && QUEUE_EMPTY) |=> ERR_CODE == cec_pkg::ERR_NONE)
    else $error("empty queue read did not return zero");
  chk_count_bound: assert property (@(posedge CLOCK) disable iff (!RESETN)
    cnt_q <= (AW+1)'(DEPTH))
    else $error("queue count above depth");
  chk_full_stays: assert property (@(posedge CLOCK) disable iff (!RESETN)
    (cnt_q == (AW+1)'(DEPTH) && push && !pop) |=> cnt_q == (AW+1)'(DEPTH) && ESR[cec_pkg::ESR_DEV_BIT])
    else $error("overflow not recorded");
  chk_overrun_push: assert property (@(posedge CLOCK) disable iff (!RESETN)
    (CHAR_VALID && !ovr_q && chars_q == MAX_CHARS) |-> push && push_code == cec_pkg::ERR_OVERRUN)
    else $error("overrun not recorded at limit");
  chk_refused_gate: assert property (@(posedge CLOCK) disable iff (!RESETN)
    (FAULT_VALID && FAULT_KIND != cec_pkg::CEC_F_NONE &&
      !(FAULT_KIND == cec_pkg::CEC_F_PROTECTED && PASSWORD_UNLOCK_ACTIVE))
    |-> !CMD_ACCEPT ##1 !QUEUE_EMPTY)
    else $error("refused command accepted or not queued");
endmodule
`default_nettype wire

/* File: logic/cec_pkg.sv */
`default_nettype none
package cec_pkg;
  // Error codes as signed 16-bit values.
  localparam logic signed [15:0] ERR_NONE = 16'sh0000;
  localparam logic signed [15:0] ERR_NUMERIC = -16'sd120;
  localparam logic signed [15:0] ERR_EXPONENT = -16'sd123;
  localparam logic signed [15:0] ERR_PROTECTED = -16'sd203;
  localparam logic signed [15:0] ERR_CONFLICT = -16'sd221;
  localparam logic signed [15:0] ERR_RANGE = -16'sd222;
  localparam logic signed [15:0] ERR_TOO_MUCH = -16'sd223;
  localparam logic signed [15:0] ERR_ILLEGAL = -16'sd224;
  localparam logic signed [15:0] ERR_LIST_LEN = -16'sd226;
  localparam logic signed [15:0] ERR_OVERFLOW = -16'sd350;
  localparam logic signed [15:0] ERR_OVERRUN = -16'sd363;
  // Event status register bit positions.
  localparam int ESR_DEV_BIT = 3;
  localparam int ESR_EXE_BIT = 4;
  localparam int ESR_CMD_BIT = 5;
  localparam int ESR_W = 8;
  localparam logic [ESR_W-1:0] ESR_RESET = 8'h00;
  // Input message length limit in characters.
  localparam int MAX_MSG_CHARS = 253;
  // Qualifier codes carried with each queued entry.
  localparam logic [2:0] Q_NONE = 3'h0;
  localparam logic [2:0] Q_OUT_OFF = 3'h1;
  localparam logic [2:0] Q_EXT_REF = 3'h2;
  localparam logic [2:0] Q_MODE = 3'h3;
  localparam logic [2:0] Q_LIST_RUN = 3'h4;
  localparam logic [2:0] Q_VOLT = 3'h1;
  localparam logic [2:0] Q_CURR = 3'h2;
  localparam logic [2:0] Q_DWELL = 3'h3;
  localparam logic [2:0] Q_TOO_SMALL = 3'h1;
  // Fault kinds reported by the parser, one per cycle.
  typedef enum logic [3:0] {
    CEC_F_NONE, CEC_F_NUMERIC, CEC_F_EXPONENT, CEC_F_PROTECTED, CEC_F_CONFLICT,
    CEC_F_RANGE, CEC_F_TOO_MUCH, CEC_F_ILLEGAL, CEC_F_LIST_LEN, CEC_F_OVERRUN
  } cec_fault_t;
endpackage
`default_nettype wire

/* File: tb/cec_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module cec_host_model (
  // Clock.
  input wire logic CLOCK,
  // Host side of the input stream and the error queue.
  output logic CHAR_VALID,
  output logic MSG_END,
  output logic QUEUE_READ,
  input wire logic [15:0] ERR_CODE,
  input wire logic [2:0] ERR_QUAL
);
  initial begin
    CHAR_VALID = 1'b0;
    MSG_END = 1'b0;
    QUEUE_READ = 1'b0;
  end
  // A polite host stays within the length limit; longer messages are only sent when asked.
  task automatic send_msg(input int n, input logic close);
    for (int i = 0; i < n; i++) begin
      @(posedge CLOCK) CHAR_VALID <= 1'b1;
    end
    @(posedge CLOCK) CHAR_VALID <= 1'b0;
    MSG_END <= close;
    @(posedge CLOCK) MSG_END <= 1'b0;
  endtask
  // The answer lands on the same edge that takes the read.
  task automatic pop(output logic [15:0] code, output logic [2:0] qual);
    @(posedge CLOCK) QUEUE_READ <= 1'b1;
    @(posedge CLOCK) QUEUE_READ <= 1'b0;
    #1;
    code = ERR_CODE;
    qual = ERR_QUAL;
  endtask
endmodule
`default_nettype wire

/* File: tb/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int DEPTH = 4;
  logic CLOCK = 1'b0;
  logic RESETN = 1'b0;
  logic FAULT_VALID = 1'b0;
  cec_pkg::cec_fault_t FAULT_KIND = cec_pkg::CEC_F_NONE;
  logic [2:0] FAULT_QUAL = 3'h0;
  logic PASSWORD_UNLOCK_ACTIVE = 1'b0;
  logic ESR_CLEAR = 1'b0;
  logic CHAR_VALID, MSG_END, QUEUE_READ, QUEUE_EMPTY, CMD_ACCEPT, last_accept;
  logic [15:0] ERR_CODE, code;
  logic [2:0] ERR_QUAL, qual;
  logic [7:0] ESR;
  int fail_count = 0;
  int samples_checked = 0;
  always #5 CLOCK = ~CLOCK;
  cec_classifier #(.DEPTH(DEPTH), .QW(3)) uut (.CLOCK(CLOCK), .RESETN(RESETN), .FAULT_VALID(FAULT_VALID),
    .FAULT_KIND(FAULT_KIND), .FAULT_QUAL(FAULT_QUAL), .PASSWORD_UNLOCK_ACTIVE(PASSWORD_UNLOCK_ACTIVE),
    .CHAR_VALID(CHAR_VALID), .MSG_END(MSG_END), .QUEUE_READ(QUEUE_READ), .ERR_CODE(ERR_CODE),
    .ERR_QUAL(ERR_QUAL), .QUEUE_EMPTY(QUEUE_EMPTY), .ESR_CLEAR(ESR_CLEAR), .ESR(ESR), .CMD_ACCEPT(CMD_ACCEPT));
  cec_host_model host (.CLOCK(CLOCK), .CHAR_VALID(CHAR_VALID), .MSG_END(MSG_END), .QUEUE_READ(QUEUE_READ),
    .ERR_CODE(ERR_CODE), .ERR_QUAL(ERR_QUAL));
  task automatic report_and_stop;
    $display("mismatches %0d comparisons %0d", fail_count, samples_checked);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] seen);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic fault(input cec_pkg::cec_fault_t k, input logic [2:0] q);
    @(posedge CLOCK);
    FAULT_VALID <= 1'b1;
    FAULT_KIND <= k;
    FAULT_QUAL <= q;
    #1 last_accept = CMD_ACCEPT;
    @(posedge CLOCK);
    FAULT_VALID <= 1'b0;
  endtask
  task automatic clear_esr;
    @(posedge CLOCK) ESR_CLEAR <= 1'b1;
    @(posedge CLOCK) ESR_CLEAR <= 1'b0;
  endtask
  task automatic check_one(input cec_pkg::cec_fault_t k, input logic [2:0] q, input logic [15:0] c, input int b);
    clear_esr();
    fault(k, q);
    #1;
    chk("ESR", 16'(8'h01 << b), 16'(ESR));
    chk("CMD_ACCEPT", 16'h0000, 16'(last_accept));
    host.pop(code, qual);
    chk("ERR_CODE", c, code);
    chk("ERR_QUAL", 16'(q), 16'(qual));
  endtask
  task automatic check_reset;
    chk("ERR_CODE", 16'h0000, ERR_CODE);
    chk("ESR", 16'h0000, 16'(ESR));
    chk("QUEUE_EMPTY", 16'h0001, 16'(QUEUE_EMPTY));
    host.pop(code, qual);
    chk("ERR_CODE", cec_pkg::ERR_NONE, code);
  endtask
  task automatic check_unlocked;
    @(posedge CLOCK) PASSWORD_UNLOCK_ACTIVE <= 1'b1;
    fault(cec_pkg::CEC_F_PROTECTED, 3'h0);
    #1 chk("QUEUE_EMPTY", 16'h0001, 16'(QUEUE_EMPTY));
    chk("CMD_ACCEPT", 16'h0001, 16'(last_accept));
    chk("ESR", 16'h0010, 16'(ESR));
    @(posedge CLOCK) PASSWORD_UNLOCK_ACTIVE <= 1'b0;
  endtask
  // A fault and a status clear in one cycle: the clear drops old bits, the new bit survives.
  task automatic check_clear_race;
    @(posedge CLOCK);
    FAULT_VALID <= 1'b1;
    FAULT_KIND <= cec_pkg::CEC_F_RANGE;
    FAULT_QUAL <= cec_pkg::Q_DWELL;
    ESR_CLEAR <= 1'b1;
    @(posedge CLOCK);
    FAULT_VALID <= 1'b0;
    ESR_CLEAR <= 1'b0;
    #1 chk("ESR", 16'h0010, 16'(ESR));
    host.pop(code, qual);
    chk("ERR_CODE", cec_pkg::ERR_RANGE, code);
    chk("ERR_QUAL", 16'(cec_pkg::Q_DWELL), 16'(qual));
  endtask
  task automatic check_order;
    fault(cec_pkg::CEC_F_NUMERIC, 3'h0);
    fault(cec_pkg::CEC_F_RANGE, cec_pkg::Q_CURR);
    fault(cec_pkg::CEC_F_LIST_LEN, 3'h0);
    host.pop(code, qual);
    chk("ERR_CODE", cec_pkg::ERR_NUMERIC, code);
    host.pop(code, qual);
    chk("ERR_CODE", cec_pkg::ERR_RANGE, code);
    host.pop(code, qual);
    chk("ERR_CODE", cec_pkg::ERR_LIST_LEN, code);
    host.pop(code, qual);
    chk("ERR_CODE", cec_pkg::ERR_NONE, code);
  endtask
  task automatic check_overflow;
    clear_esr();
    @(posedge CLOCK);
    FAULT_VALID <= 1'b1;
    FAULT_KIND <= cec_pkg::CEC_F_RANGE;
    FAULT_QUAL <= cec_pkg::Q_VOLT;
    repeat (DEPTH + 1) @(posedge CLOCK);
    FAULT_VALID <= 1'b0;
    #1 chk("ESR", 16'h0018, 16'(ESR));
    for (int i = 0; i < DEPTH; i++) begin
      host.pop(code, qual);
      chk("ERR_CODE", (i == DEPTH - 1) ? cec_pkg::ERR_OVERFLOW : cec_pkg::ERR_RANGE, code);
    end
    chk("QUEUE_EMPTY", 16'h0001, 16'(QUEUE_EMPTY));
  endtask
  task automatic check_overrun;
    clear_esr();
    host.send_msg(253, 1'b1);
    #1 chk("QUEUE_EMPTY", 16'h0001, 16'(QUEUE_EMPTY));
    host.send_msg(254, 1'b1);
    #1 chk("ESR", 16'h0008, 16'(ESR));
    host.pop(code, qual);
    chk("ERR_CODE", cec_pkg::ERR_OVERRUN, code);
  endtask
  initial begin
    repeat (10) @(posedge CLOCK);
    RESETN <= 1'b1;
    check_reset();
    check_one(cec_pkg::CEC_F_NUMERIC, cec_pkg::Q_NONE, cec_pkg::ERR_NUMERIC, 5);
    check_one(cec_pkg::CEC_F_EXPONENT, cec_pkg::Q_NONE, cec_pkg::ERR_EXPONENT, 5);
    check_one(cec_pkg::CEC_F_PROTECTED, cec_pkg::Q_NONE, cec_pkg::ERR_PROTECTED, 4);
    for (int q = 1; q <= 4; q++) begin
      check_one(cec_pkg::CEC_F_CONFLICT, 3'(q), cec_pkg::ERR_CONFLICT, 4);
    end
    for (int q = 0; q <= 3; q++) begin
      check_one(cec_pkg::CEC_F_RANGE, 3'(q), cec_pkg::ERR_RANGE, 4);
    end
    check_one(cec_pkg::CEC_F_TOO_MUCH, cec_pkg::Q_NONE, cec_pkg::ERR_TOO_MUCH, 4);
    check_one(cec_pkg::CEC_F_ILLEGAL, cec_pkg::Q_NONE, cec_pkg::ERR_ILLEGAL, 4);
    check_one(cec_pkg::CEC_F_OVERRUN, cec_pkg::Q_NONE, cec_pkg::ERR_OVERRUN, 3);
    check_one(cec_pkg::CEC_F_LIST_LEN, cec_pkg::Q_NONE, cec_pkg::ERR_LIST_LEN, 4);
    check_one(cec_pkg::CEC_F_LIST_LEN, cec_pkg::Q_TOO_SMALL, cec_pkg::ERR_LIST_LEN, 4);
    check_unlocked();
    check_order();
    check_clear_race();
    check_overflow();
    check_overrun();
    report_and_stop();
  end
  initial begin
    repeat (20000) @(posedge CLOCK);
    fail_count++;
    report_and_stop();
  end
endmodule
`default_nettype wire
